/* File: hw/vbi_insert_picture_adjust.sv */
// vbi_insert_picture_adjust.sv: teletext request timing, copy-generation and
// wide-screen word building, luma/chroma scaling, hue and brightness
// assumes: clk is the pixel clock; pixel and timing inputs are on clk
`include "vbi_defs.svh"

module vbi_insert_picture_adjust (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial control port pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // video and timing in
  input wire vbi_pkg::pix_s pix_in,
  input wire vbi_pkg::timing_s timing_in,
  // video out and vbi words
  output vbi_pkg::pix_s pix_out,
  output logic teletext_request_strobe,
  output vbi_pkg::cgms_s cgms_out,
  output vbi_pkg::wss_s wss_out
);

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------

  // crc x^6+x+1 over the fourteen leading copy-gen bits, first bit first
  function automatic logic [5:0] crc6(input logic [13:0] d);
    logic [5:0] c;
    logic fb;
    c = `CRC_INIT;
    fb = 1'b0;
    for (int i = 13; i >= 0; i--) begin
      fb = d[i] ^ c[5];
      c = {c[4:0], fb} ^ {4'h0, fb, 1'b0};
    end
    return c;
  endfunction

  // signed chroma times unsigned scale over 128, saturated to 8 bits
  function automatic logic [7:0] scale_s8(input logic [7:0] c, input logic [7:0] k);
    logic signed [16:0] p;
    logic [9:0] s;
    p = $signed(c) * $signed({1'b0, k});
    s = p[16:7];
    if ($signed(s) > $signed(`CHROMA_MAX)) begin
      s = `CHROMA_MAX;
    end else if ($signed(s) < $signed(`CHROMA_MIN)) begin
      s = `CHROMA_MIN;
    end
    return s[7:0];
  endfunction

  // ------------------------------------------------------------
  // register access
  // ------------------------------------------------------------
  vbi_pkg::regs_s regs_q, regs_d;
  logic wr;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] anchor_q, anchor_d;

  serial_ctrl_port u_port (
    .clk(clk),
    .resetn(resetn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .wr(wr),
    .addr(addr),
    .wdata(wdata),
    .rdata(rdata)
  );

  // read-back of the bank; unmapped subaddresses read zero
  always_comb begin
    case (addr)
      `REG_CGW0: rdata = regs_q.cgw0;
      `REG_CGW1: rdata = regs_q.cgw1;
      `REG_CGW2: rdata = regs_q.cgw2;
      `REG_TTX: rdata = regs_q.ttx;
      `REG_LUMA: rdata = regs_q.luma;
      `REG_USCL: rdata = regs_q.uscl;
      `REG_VSCL: rdata = regs_q.vscl;
      `REG_HUE: rdata = regs_q.hue;
      `REG_BRIGHT: rdata = regs_q.bright;
      default: rdata = `RST_ZERO;
    endcase
  end

  // register writes and falling-edge anchor
  always_comb begin
    regs_d = regs_q;
    anchor_d = anchor_q;
    if (wr) begin
      case (addr)
        `REG_CGW0: regs_d.cgw0 = wdata;
        `REG_CGW1: regs_d.cgw1 = wdata;
        `REG_CGW2: regs_d.cgw2 = wdata;
        `REG_TTX: regs_d.ttx = wdata;
        `REG_LUMA: regs_d.luma = wdata;
        `REG_USCL: regs_d.uscl = wdata;
        `REG_VSCL: regs_d.vscl = wdata;
        `REG_HUE: regs_d.hue = wdata;
        `REG_BRIGHT: regs_d.bright = wdata;
        default: regs_d = regs_q;
      endcase
    end
    if (regs_q.ttx[3:0] == 4'h0) begin
      anchor_d = regs_q.ttx[7:4];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      regs_q <= {`RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_SCALE, `RST_SCALE,
                 `RST_SCALE, `RST_HUE, `RST_ZERO};
      anchor_q <= 4'h0;
    end else begin
      regs_q <= regs_d;
      anchor_q <= anchor_d;
    end
  end

  // ------------------------------------------------------------
  // teletext request strobe
  // ------------------------------------------------------------
  logic [10:0] pos_q, pos_d, rise_at, fall_at;
  logic [3:0] anchor_eff;
  logic line_q, line_d, ttx_q, ttx_d;

  assign rise_at = `TTX_START + {7'h00, regs_q.ttx[7:4]};
  assign anchor_eff = (regs_q.ttx[3:0] == 4'h0) ? regs_q.ttx[7:4] : anchor_q;
  assign fall_at = `TTX_START + `TTX_LEN + {7'h00, anchor_eff} - {7'h00, regs_q.ttx[3:0]};

  // pixel counter within the line and the request window
  always_comb begin
    pos_d = pos_q;
    line_d = line_q;
    if (timing_in.line_start) begin
      pos_d = 11'h000;
      line_d = timing_in.ttx_line;
    end else if (pos_q != `TTX_CNT_MAX) begin
      pos_d = pos_q + 11'h001;
    end
    ttx_d = ttx_q;
    if (timing_in.line_start || pos_q == fall_at) begin
      ttx_d = 1'b0;
    end else if (line_q && pos_q == rise_at) begin
      ttx_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pos_q <= `TTX_CNT_MAX;
      line_q <= 1'b0;
      ttx_q <= 1'b0;
    end else begin
      pos_q <= pos_d;
      line_q <= line_d;
      ttx_q <= ttx_d;
    end
  end

  // ------------------------------------------------------------
  // copy-generation and wide-screen words
  // ------------------------------------------------------------
  vbi_pkg::cgms_s cgms_q, cgms_d;
  vbi_pkg::wss_s wss_q, wss_d;
  logic [19:0] cg_raw;
  logic cg_field_en;

  // stream order: second, third, then tail nibble
  assign cg_raw = {regs_q.cgw1, regs_q.cgw2, regs_q.cgw0[3:0]};
  assign cg_field_en = timing_in.field_odd ? regs_q.cgw0[`CGW0_ODD_EN]
                                           : regs_q.cgw0[`CGW0_EVEN_EN];

  // words issued once at each field start, copy-gen in ntsc and wide-screen in pal fields
  always_comb begin
    cgms_d = '0;
    wss_d = '0;
    cgms_d.word = cg_raw;
    // internal crc on last six bits
    if (regs_q.cgw0[`CGW0_CRC_AUTO]) begin
      cgms_d.word = {cg_raw[19:6], crc6(cg_raw[19:6])};
    end
    cgms_d.valid = timing_in.field_start && !timing_in.pal && cg_field_en;
    wss_d.word = {regs_q.cgw2, regs_q.cgw1[5:0]};
    wss_d.valid = timing_in.field_start && timing_in.pal && regs_q.cgw0[`CGW0_WSS_EN];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cgms_q <= '0;
      wss_q <= '0;
    end else begin
      cgms_q <= cgms_d;
      wss_q <= wss_d;
    end
  end

  // ------------------------------------------------------------
  // picture adjust path, one clock of latency
  // ------------------------------------------------------------
  vbi_pkg::pix_s pix_q, pix_d;
  logic [7:0] luma_k;
  logic [15:0] y_prod;
  logic signed [11:0] y_sum;
  logic [8:0] hue_delta;
  logic [15:0] hue_off;

  assign luma_k = (regs_q.luma > `LUMA_SCALE_MAX) ? `LUMA_SCALE_MAX : regs_q.luma;
  assign y_prod = {8'h00, pix_in.y} * {8'h00, luma_k};
  assign y_sum = $signed({3'b000, y_prod[15:7]}) +
                 $signed({{5{regs_q.bright[6]}}, regs_q.bright[6:0]});
  // one step is 1/2048 turn, 32 phase units
  assign hue_delta = {1'b0, regs_q.hue} - `HUE_CENTER;
  assign hue_off = {{2{hue_delta[8]}}, hue_delta, 5'h00};

  // scaled, offset and saturated pixel, phase shifted in active video only
  always_comb begin
    pix_d = pix_in;
    if (y_sum < 0) begin
      pix_d.y = 8'h00;
    end else if (y_sum > $signed(`LUMA_MAX)) begin
      pix_d.y = 8'hFF;
    end else begin
      pix_d.y = y_sum[7:0];
    end
    pix_d.u = scale_s8(pix_in.u, regs_q.uscl);
    pix_d.v = scale_s8(pix_in.v, regs_q.vscl);
    if (pix_in.active) begin
      pix_d.phase = pix_in.phase + hue_off;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pix_q <= '0;
    end else begin
      pix_q <= pix_d;
    end
  end

  assign pix_out = pix_q;
  assign teletext_request_strobe = ttx_q;
  assign cgms_out = cgms_q;
  assign wss_out = wss_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  strobe_rise_at_a: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(ttx_q) |-> $past(pos_q) == $past(rise_at) && $past(line_q))
    else $error("request strobe rose at wrong position");

  strobe_fall_at_a: assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(ttx_q) |-> $past(pos_q) == $past(fall_at) || $past(timing_in.line_start))
    else $error("request strobe fell at wrong position");

  fall_tracks_a: assert property (
    @(posedge clk) disable iff (!resetn)
    regs_q.ttx[3:0] == 4'h0 |=> anchor_q == $past(regs_q.ttx[7:4]))
    else $error("falling edge anchor did not follow rising edge");

  crc_auto_a: assert property (
    @(posedge clk) disable iff (!resetn)
    cgms_q.valid && $past(regs_q.cgw0[`CGW0_CRC_AUTO]) |->
      cgms_q.word[5:0] == crc6(cgms_q.word[19:6]))
    else $error("copy-gen crc mismatch");

  cgms_ntsc_a: assert property (
    @(posedge clk) disable iff (!resetn)
    cgms_q.valid |-> !$past(timing_in.pal) && $past(cg_field_en))
    else $error("copy-gen word outside enabled ntsc field");

  wss_pal_a: assert property (
    @(posedge clk) disable iff (!resetn)
    timing_in.field_start && timing_in.pal && regs_q.cgw0[`CGW0_WSS_EN] |=>
      wss_q.valid && !cgms_q.valid)
    else $error("wide-screen word missing in pal field");

  luma_unity_a: assert property (
    @(posedge clk) disable iff (!resetn)
    regs_q.luma == `RST_SCALE && regs_q.bright == `RST_ZERO |=> pix_q.y == $past(pix_in.y))
    else $error("unity luma scale changed the pixel");

  chroma_zero_a: assert property (
    @(posedge clk) disable iff (!resetn)
    regs_q.uscl == `RST_ZERO |=> pix_q.u == 8'h00)
    else $error("zero u scale left chroma");

  v_scale_zero_a: assert property (
    @(posedge clk) disable iff (!resetn)
    regs_q.vscl == `RST_ZERO |=> pix_q.v == 8'h00)
    else $error("zero v scale left chroma");

  hue_center_a: assert property (
    @(posedge clk) disable iff (!resetn)
    regs_q.hue == `RST_HUE || !pix_in.active |=> pix_q.phase == $past(pix_in.phase))
    else $error("phase shifted at zero hue or outside active video");

endmodule

/* File: hw/vbi_defs.svh */
// vbi_defs.svh: constants of the vbi insertion and picture adjust block
// assumes: included by bare name from the two design modules
`ifndef VBI_DEFS_SVH
`define VBI_DEFS_SVH

// ------------------------------------------------------------
// register subaddresses
// ------------------------------------------------------------
`define REG_CGW0 8'h19
`define REG_CGW1 8'h1A
`define REG_CGW2 8'h1B
`define REG_TTX 8'h1C
`define REG_LUMA 8'h1D
`define REG_USCL 8'h1E
`define REG_VSCL 8'h1F
`define REG_HUE 8'h20
`define REG_BRIGHT 8'h21

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_ZERO 8'h00
`define RST_SCALE 8'h80
`define RST_HUE 8'h80

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CGW0_CRC_AUTO 4
`define CGW0_ODD_EN 5
`define CGW0_EVEN_EN 6
`define CGW0_WSS_EN 7

// ------------------------------------------------------------
// arithmetic and timing constants (counts in pixel clocks)
// ------------------------------------------------------------
`define LUMA_SCALE_MAX 8'hC0
`define HUE_CENTER 9'h080
`define CRC_INIT 6'h3F
`define TTX_START 11'h040
`define TTX_LEN 11'h168
`define TTX_CNT_MAX 11'h7FF
`define LUMA_MAX 12'h0FF
`define CHROMA_MAX 10'h07F
`define CHROMA_MIN 10'h380

// arbitrary 7-bit serial device address
`define DEV_ADDR 7'h2A

`endif

/* File: hw/vbi_pkg.sv */
// vbi_pkg.sv: carrier types of the vbi insertion and picture adjust block
// assumes: nothing beyond the constants header
package vbi_pkg;

  // one pixel with its subcarrier phase
  typedef struct packed {
    logic active;
    logic [7:0] y;
    logic [7:0] u;
    logic [7:0] v;
    logic [15:0] phase;
  } pix_s;

  // line and field timing from the timing generator
  typedef struct packed {
    logic line_start;
    logic ttx_line;
    logic field_start;
    logic field_odd;
    logic pal;
  } timing_s;

  // copy-generation word handed to the vbi inserter
  typedef struct packed {
    logic valid;
    logic [19:0] word;
  } cgms_s;

  // wide-screen word handed to the vbi inserter
  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } wss_s;

  // register bank
  typedef struct packed {
    logic [7:0] cgw0;
    logic [7:0] cgw1;
    logic [7:0] cgw2;
    logic [7:0] ttx;
    logic [7:0] luma;
    logic [7:0] uscl;
    logic [7:0] vscl;
    logic [7:0] hue;
    logic [7:0] bright;
  } regs_s;

  // serial control port states
  typedef enum logic [3:0] {
    SP_IDLE, SP_DEV, SP_DEV_ACK, SP_SUB, SP_SUB_ACK, SP_WDATA, SP_WACK, SP_RDATA, SP_RACK
  } sp_state_e;

endpackage

/* File: hw/serial_ctrl_port.sv */
// serial_ctrl_port.sv: two-wire serial control port slave
// assumes: scl and sda are raw pins; sda is open drain, driven low when oe is high
`include "vbi_defs.svh"

module serial_ctrl_port (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // register access
  output logic wr,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);

  vbi_pkg::sp_state_e st_q, st_d;
  logic [2:0] scl_q, sda_q;
  logic [7:0] sh_q, sh_d, sub_q, sub_d, wd_q, wd_d;
  logic [3:0] cnt_q, cnt_d;
  logic oe_q, oe_d, wr_q, wr_d;
  logic scl_rise, scl_fall, start, stop;

  // edges seen only after the two-stage synchronisers
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start = scl_q[1] & ~sda_q[1] & sda_q[2];
  assign stop = scl_q[1] & sda_q[1] & ~sda_q[2];

  // byte engine: address, subaddress, auto-incremented data
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    sub_d = sub_q;
    wd_d = wd_q;
    cnt_d = cnt_q;
    oe_d = oe_q;
    wr_d = 1'b0;
    if (start) begin
      st_d = vbi_pkg::SP_DEV;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop) begin
      st_d = vbi_pkg::SP_IDLE;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        vbi_pkg::SP_DEV, vbi_pkg::SP_SUB, vbi_pkg::SP_WDATA: begin
          if (scl_rise && cnt_q != 4'h8) begin
            sh_d = {sh_q[6:0], sda_q[1]};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            oe_d = 1'b1;
            if (st_q == vbi_pkg::SP_DEV) begin
              st_d = (sh_q[7:1] == `DEV_ADDR) ? vbi_pkg::SP_DEV_ACK : vbi_pkg::SP_IDLE;
              oe_d = (sh_q[7:1] == `DEV_ADDR);
            end else if (st_q == vbi_pkg::SP_SUB) begin
              st_d = vbi_pkg::SP_SUB_ACK;
              sub_d = sh_q;
            end else begin
              st_d = vbi_pkg::SP_WACK;
              wd_d = sh_q;
              wr_d = 1'b1;
            end
          end
        end
        vbi_pkg::SP_DEV_ACK, vbi_pkg::SP_SUB_ACK, vbi_pkg::SP_WACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            cnt_d = 4'h0;
            if (st_q == vbi_pkg::SP_WACK) begin
              sub_d = sub_q + 8'h01;
              st_d = vbi_pkg::SP_WDATA;
            end else if (st_q == vbi_pkg::SP_SUB_ACK) begin
              st_d = vbi_pkg::SP_WDATA;
            end else if (sh_q[0]) begin
              st_d = vbi_pkg::SP_RDATA;
              sh_d = rdata;
              oe_d = ~rdata[7];
              cnt_d = 4'h1;
            end else begin
              st_d = vbi_pkg::SP_SUB;
            end
          end
        end
        vbi_pkg::SP_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              oe_d = 1'b0;
              st_d = vbi_pkg::SP_RACK;
            end else begin
              oe_d = ~sh_q[6];
              sh_d = {sh_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        vbi_pkg::SP_RACK: begin
          if (scl_rise) begin
            cnt_d = sda_q[1] ? 4'h0 : 4'h1;
            sub_d = sda_q[1] ? sub_q : sub_q + 8'h01;
          end else if (scl_fall) begin
            // acked read goes straight on with the next byte, cnt already 1
            if (cnt_q == 4'h1) begin
              st_d = vbi_pkg::SP_RDATA;
              sh_d = rdata;
              oe_d = ~rdata[7];
            end else begin
              st_d = vbi_pkg::SP_IDLE;
            end
          end
        end
        default: st_d = vbi_pkg::SP_IDLE;
      endcase
    end
  end

  // state registers and synchronisers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= vbi_pkg::SP_IDLE;
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      sh_q <= 8'h00;
      sub_q <= 8'h00;
      wd_q <= 8'h00;
      cnt_q <= 4'h0;
      oe_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
      sh_q <= sh_d;
      sub_q <= sub_d;
      wd_q <= wd_d;
      cnt_q <= cnt_d;
      oe_q <= oe_d;
      wr_q <= wr_d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign wr = wr_q;
  assign addr = sub_q;
  assign wdata = wd_q;

endmodule

/* File: test/ttx_source.sv */
// ttx_source.sv: teletext data source model answering the request strobe
// assumes: line start and strobe are sampled on the pixel clock
module ttx_source (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // request side
  input wire logic line_start,
  input wire logic strobe,
  // results for the bench
  output int first,
  output int bits
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc;

  // cycle index since line start, first requested cycle and bits handed out
  always @(posedge clk) begin
    if (!resetn || line_start) begin
      cyc <= 1;
      first <= 0;
      bits <= 0;
    end else begin
      cyc <= cyc + 1;
      if (strobe) begin
        bits <= bits + 1;
        if (first == 0) first <= cyc;
      end
    end
  end
endmodule

/* File: test/tb_top.sv */
// tb_top.sv: self-checking bench of the vbi insertion and picture adjust block
// assumes: serial port at device address 2A, pixel clock of 40 MHz
`define CHECK_EQ(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: %h expected %h", $time, a, e); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic resetn = 0;
  logic scl_m = 1;
  logic sda_m = 1;
  logic sda_o, sda_oe, strobe;
  wire logic sda_w;
  vbi_pkg::pix_s pix_in = '0;
  vbi_pkg::pix_s pix_out;
  vbi_pkg::timing_s timing_in = '0;
  vbi_pkg::cgms_s cgms_out;
  vbi_pkg::wss_s wss_out;
  logic [7:0] rg [9];
  logic [7:0] rst [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00};
  logic [7:0] cfg [4][4] = '{'{8'h80, 8'h80, 8'h80, 8'h80}, '{8'hFF, 8'hFF, 8'h00, 8'hFF},
    '{8'h97, 8'h00, 8'hFF, 8'h00}, '{8'h00, 8'h97, 8'h69, 8'h97}};
  logic [7:0] tt [6] = '{8'h00, 8'h05, 8'h30, 8'hF0, 8'hFF, 8'h7F};
  real ire [4] = '{0.0, 20.0, -7.0, 15.0};
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int first, bits;
  int anchor = 0;

  // open-drain data line seen by the design
  assign sda_w = sda_m & ~sda_oe;

  vbi_insert_picture_adjust u_dut (
    .clk(clk), .resetn(resetn), .scl_i(scl_m), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .pix_in(pix_in), .timing_in(timing_in), .pix_out(pix_out),
    .teletext_request_strobe(strobe), .cgms_out(cgms_out), .wss_out(wss_out));

  ttx_source u_src (
    .clk(clk), .resetn(resetn), .line_start(timing_in.line_start), .strobe(strobe),
    .first(first), .bits(bits));

  // pixel clock
  always #12.5 clk = ~clk;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic test_done;
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one serial bit: data set while clock low, line sampled mid high phase
  task automatic sbit(input logic v, output logic s);
    wait_clk(1);
    sda_m <= v;
    wait_clk(5);
    scl_m <= 1;
    wait_clk(5);
    s = sda_w;
    wait_clk(4);
    scl_m <= 0;
  endtask

  task automatic xfer(input logic [7:0] b, input logic mack, output logic [7:0] r,
                      output logic ack);
    for (int i = 0; i < 8; i++) sbit(b[7 - i], r[7 - i]);
    sbit(mack, ack);
  endtask

  task automatic start_c;
    wait_clk(1);
    sda_m <= 1;
    wait_clk(6);
    scl_m <= 1;
    wait_clk(6);
    sda_m <= 0;
    wait_clk(6);
    scl_m <= 0;
  endtask

  task automatic stop_c;
    wait_clk(1);
    sda_m <= 0;
    wait_clk(6);
    scl_m <= 1;
    wait_clk(6);
    sda_m <= 1;
    wait_clk(6);
  endtask

  task automatic wr_reg(input logic [7:0] sub, input logic [7:0] d);
    logic [7:0] r;
    logic a;
    start_c();
    xfer(8'h54, 1'b1, r, a);
    `CHECK_EQ(a, 1'b0) // address acknowledged
    `CHECK_EQ(sda_o, 1'b0) // open-drain level
    xfer(sub, 1'b1, r, a);
    xfer(d, 1'b1, r, a);
    `CHECK_EQ(a, 1'b0) // data acknowledged
    stop_c();
    if (sub >= 8'h19 && sub <= 8'h21) rg[sub - 8'h19] = d;
  endtask

  function automatic int sat(input int x, input int lo, input int hi);
    return x < lo ? lo : (x > hi ? hi : x);
  endfunction

  function automatic logic [6:0] enc_bright(input real v);
    return 7'(int'(v * 2.015631));
  endfunction

  // pixel reference built from the shadow registers
  function automatic vbi_pkg::pix_s pmodel(input vbi_pkg::pix_s p);
    vbi_pkg::pix_s o;
    int l;
    l = (rg[4] > 8'hC0) ? 192 : int'(rg[4]);
    o.active = p.active;
    o.y = 8'(sat(int'(p.y) * l / 128 + int'($signed(rg[8][6:0])), 0, 255));
    o.u = 8'(sat(($signed(p.u) * int'(rg[5])) >>> 7, -128, 127));
    o.v = 8'(sat(($signed(p.v) * int'(rg[6])) >>> 7, -128, 127));
    o.phase = p.active ? p.phase + 16'((int'(rg[7]) - 128) * 32) : p.phase;
    return o;
  endfunction

  function automatic logic [5:0] crc6(input logic [13:0] d);
    logic [5:0] c;
    logic fb;
    c = 6'h3F;
    for (int i = 13; i >= 0; i--) begin
      fb = d[i] ^ c[5];
      c = {c[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
    end
    return c;
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] r;
    logic a;
    logic pal, odd;
    logic [19:0] w;
    logic [13:0] ww;
    vbi_pkg::pix_s p;
    vbi_pkg::pix_s q [$];
    void'($urandom(97));
    for (int i = 0; i < 9; i++) rg[i] = rst[i];
    wait_clk(8);
    resetn <= 1;
    wait_clk(4);
    // reset values, auto increment and the unmapped place after the bank
    start_c();
    xfer(8'h54, 1'b1, r, a);
    xfer(8'h19, 1'b1, r, a);
    start_c();
    xfer(8'h55, 1'b1, r, a);
    for (int i = 0; i < 10; i++) begin
      xfer(8'hFF, i == 9, r, a);
      `CHECK_EQ(r, rst[i]) // read back
    end
    stop_c();
    // foreign device address is left unanswered
    start_c();
    xfer(8'h56, 1'b1, r, a);
    `CHECK_EQ(a, 1'b1) // no acknowledge
    stop_c();
    // scaling, hue and brightness against random back-to-back pixels
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) wr_reg(8'(8'h1D + k), cfg[c][k]);
      wr_reg(8'h21, {1'b1, enc_bright(ire[c])});
      q.delete();
      for (int n = 0; n < 40; n++) begin
        @(posedge clk);
        p = 41'({$urandom, $urandom});
        pix_in <= p;
        q.push_back(p);
        // output settled mid cycle shows the pixel driven one edge earlier
        @(negedge clk);
        if (q.size() == 2) begin
          p = q.pop_front();
          `CHECK_EQ(pix_out, pmodel(p))
        end
      end
    end
    // teletext request window, last line without teletext
    for (int t = 0; t < 7; t++) begin
      if (t < 6) wr_reg(8'h1C, tt[t]);
      if (rg[3][3:0] == 4'h0) anchor = int'(rg[3][7:4]);
      @(posedge clk);
      timing_in.line_start <= 1;
      timing_in.ttx_line <= (t < 6);
      @(posedge clk);
      timing_in.line_start <= 0;
      wait_clk(480);
      `CHECK_EQ(bits, t < 6 ? 360 + anchor - int'(rg[3][7:4]) - int'(rg[3][3:0]) : 0)
      if (t < 6) `CHECK_EQ(first, 66 + int'(rg[3][7:4])) // rise position
    end
    // copy-generation and wide-screen words over both standards and fields
    for (int i = 0; i < 12; i++) begin
      wr_reg(8'h19, 8'($urandom));
      wr_reg(8'h1A, 8'($urandom));
      wr_reg(8'h1B, 8'($urandom));
      pal = i[0];
      odd = i[1];
      @(posedge clk);
      timing_in.field_start <= 1;
      timing_in.field_odd <= odd;
      timing_in.pal <= pal;
      @(posedge clk);
      timing_in.field_start <= 0;
      // words are looked at mid cycle, where the registered pulse stands
      @(negedge clk);
      w = {rg[1], rg[2], rg[0][3:0]};
      if (rg[0][4]) w[5:0] = crc6(w[19:6]);
      ww = {rg[2], rg[1][5:0]};
      `CHECK_EQ(cgms_out.valid, !pal && (odd ? rg[0][5] : rg[0][6]))
      if (cgms_out.valid === 1'b1) `CHECK_EQ(cgms_out.word, w)
      `CHECK_EQ(wss_out.valid, pal && rg[0][7])
      if (wss_out.valid === 1'b1) `CHECK_EQ(wss_out.word, ww)
      @(negedge clk);
      `CHECK_EQ(cgms_out.valid | wss_out.valid, 1'b0) // single pulse
    end
    test_done();
  end
endmodule
